// ===== hdl/spe_pkg.sv
// Purpose: Shared constants, types and helpers of the serial memory slave
// Assumes: Core clock of 200 MHz; link clock from the host
// Notes: Opcodes, addresses and data travel MSB first
`default_nettype none
package spe_pkg;
   // ****************
   // Timing
   // ****************
   localparam int unsigned CLK_MHZ = 200; // Core clock rate
   localparam int unsigned WR_TIME_US = 1000; // Self-timed write time
   localparam int unsigned WR_CYC = WR_TIME_US * CLK_MHZ; // Cycles
   localparam int CNT_W = 24; // Write timer width
   // ****************
   // Opcodes
   // ****************
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_CLR_LATCH = 8'h04;
   localparam logic [7:0] OP_RD_STAT = 8'h05;
   localparam logic [7:0] OP_WR_STAT = 8'h01;
   localparam logic [7:0] OP_ARR_MASK = 8'hF7; // Hides address bit
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam int OP_A8_POS = 3; // Upper address bit in opcode
   // ****************
   // Array and status
   // ****************
   localparam int MEM_DEPTH = 512;
   localparam int PAGE_BYTES = 4;
   localparam logic [2:0] BYTE_LAST = 3'h7;
   localparam logic [1:0] PROT_INIT = 2'h0; // Stored protect code
   localparam logic [1:0] PROT_NONE = 2'h0;
   localparam logic [1:0] PROT_QTR = 2'h1;
   localparam logic [1:0] PROT_HALF = 2'h2;
   localparam logic [8:0] QTR_BASE = 9'h180;
   localparam logic [8:0] HALF_BASE = 9'h100;
   localparam logic [7:0] ST_BUSY_ALL = 8'hFF; // Read while writing
   localparam logic [3:0] ST_HI_FILL = 4'h0; // Unused status bits
   localparam int ST_PROT_POS = 2; // Protect field in status
   // ****************
   // Types
   // ****************
   typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DATA, PH_RD_ARR, PH_RD_STAT, PH_IGNORE} spe_phase_t;
   typedef enum logic [1:0] {CMD_SET, CMD_CLR, CMD_ARR, CMD_STAT} spe_cmd_t;
   typedef enum logic [1:0] {WK_NONE, WK_ARR, WK_STAT} spe_wkind_t;
   // Status word as seen by the link, high bit first
   typedef struct packed {
      logic armed;
      logic [1:0] prot;
      logic latch;
      logic busy;
   } spe_stat_t;
   // Protected location test
   function automatic logic prot_hit(input logic [1:0] code, input logic [8:0] addr);
      case (code)
         PROT_NONE: prot_hit = 1'b0;
         PROT_QTR: prot_hit = (addr >= QTR_BASE);
         PROT_HALF: prot_hit = (addr >= HALF_BASE);
         default: prot_hit = 1'b1;
      endcase
   endfunction : prot_hit
   // Status byte; all ones while a write runs
   function automatic logic [7:0] stat_byte(input spe_stat_t s);
      stat_byte = s.busy ? ST_BUSY_ALL : {ST_HI_FILL, s.prot, s.latch, s.busy};
   endfunction : stat_byte
endpackage : spe_pkg
`default_nettype wire

// ===== hdl/spe_wr_if.sv
// Purpose: Launch and progress of the self-timed write cycle
// Assumes: All signals on the core clock
// Notes: Start and done are one-cycle pulses
`default_nettype none
interface spe_wr_if;
   logic start; // Launch a write cycle
   logic busy; // Write cycle running
   logic done; // Write cycle finished
   modport ctl (output start, input busy, input done);
   modport eng (input start, output busy, output done);
endinterface : spe_wr_if
`default_nettype wire

// ===== hdl/spe_wr_eng.sv
// Purpose: Self-timed write cycle timer
// Assumes: WR_CYCLES of at least 4
// Notes: Busy drops in the same cycle that done pulses
`default_nettype none
module spe_wr_eng #(
   parameter int unsigned WR_CYCLES = spe_pkg::WR_CYC
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   spe_wr_if.eng wr
);
   import spe_pkg::*;
   // ****************
   // State
   // ****************
   typedef enum logic {EN_IDLE, EN_RUN} spe_en_st_t;
   typedef struct packed {
      spe_en_st_t st; // Idle or timing
      logic [CNT_W-1:0] cnt; // Elapsed cycles
      logic done; // End pulse
   } spe_en_t;
   spe_en_t en_reg, en_next;

   // Next state; the cycle cannot be cut short once started
   always_comb begin
      en_next = en_reg;
      en_next.done = 1'b0;
      case (en_reg.st)
         EN_IDLE: begin
            if (wr.start) begin
               en_next.st = EN_RUN;
               en_next.cnt = '0;
            end
         end
         EN_RUN: begin
            if (en_reg.cnt == CNT_W'(WR_CYCLES - 1)) begin
               en_next.st = EN_IDLE;
               en_next.done = 1'b1;
            end else begin
               en_next.cnt = CNT_W'(en_reg.cnt + 1'b1);
            end
         end
         default: en_next.st = EN_IDLE;
      endcase
   end

   // Register
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         en_reg <= '0;
      end else begin
         en_reg <= en_next;
      end
   end

   assign wr.busy = (en_reg.st == EN_RUN);
   assign wr.done = en_reg.done;

   // ****************
   // Checks
   // ****************
   a_busy_holds: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(wr.busy) |=> wr.busy [*3])
      else $error("Write cycle ended too early");
   a_done_ends: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) wr.done |-> !wr.busy && $past(wr.busy))
      else $error("Done without a running write");
endmodule : spe_wr_eng
`default_nettype wire

// ===== hdl/spe_top.sv
// Purpose: Slave side of a 512-byte serial nonvolatile memory
// Assumes: Host is the serial master and owns the link clock
// Notes: Link logic runs on the link clock; write cycles on the core clock
//
// What this block does
// - Sample input bits on falling link clock
// - Change output only after rising link clock
// - Deselected: output released, standby unless writing
// - Ignore everything until select first seen high
// - Clear write latch after every write cycle unless a latch set arrives as it ends
// - Write protect low blocks nonvolatile writes only
// - Protect falling mid-frame aborts; running write continues
// - Host pauses and resumes only while clock high
// - Paused: ignore inputs, resume at same bit
// - MSB first; opcode kept in instruction register
// - First bit on first falling edge; clock static
// - Opcode 06 sets latch, 04 clears it
// - Write only completes with latch already set
// - Status read allowed anytime, even while writing
// - Status: busy, latch, two protect bits
// - Busy bit high while writing; others then one
// - Protect bits change only by status write
// - Four quarters; protect none, top, half, all
// - Opcode bit three carries upper address bit
// - Reads auto-increment and wrap at top
// - Select high ends read, releases output
// - Latch opcode must end with select rise; here the latch acts at the eighth opcode bit, rest of frame ignored
// - Write starts only on select rise after whole byte
// - Page of four bytes, address wraps in page
`default_nettype none
module spe_top #(
   parameter int unsigned WR_CYCLES = spe_pkg::WR_CYC // Write cycle length
) (
   input wire logic ref_clk_i, // Core clock
   input wire logic resetn_i, // Power-up reset
   input wire logic sck_i, // Link clock from host
   input wire logic cs_n_i, // Chip select
   input wire logic si_i, // Serial data in
   input wire logic pause_n_i, // Pause request
   input wire logic write_protect_n_i, // Write protect
   output logic so_o, // Serial data out
   output logic so_oe_o, // Output enable for so_o
   output logic standby_o // Idle and deselected
);
   import spe_pkg::*;

   // ****************
   // Storage
   // ****************
   logic [7:0] mem [0:MEM_DEPTH-1]; // Memory array
   // Link receive state, cleared by every select rise
   typedef struct packed {
      spe_phase_t ph; // Frame phase
      logic [2:0] cnt; // Bits of current byte
      logic [7:0] sh; // Input shifter
      logic [7:0] opc; // Instruction register
      logic rd; // Address is for a read
      logic [8:0] addr; // Byte address
      logic [7:0] out; // Byte being sent
      spe_stat_t st_s1; // Status sync, first stage
      spe_stat_t st_s2; // Status sync, second stage
   } spe_lk_t;
   // Link events toward the core; survive select
   typedef struct packed {
      logic cmd_t; // Command toggle
      spe_cmd_t cmd; // Command held
      logic [8:0] cmd_addr; // Address held
      logic beg_t; // Data byte begun toggle
      logic byt_t; // Data byte done toggle
      logic [7:0] byt; // Data byte held
   } spe_ev_t;
   // Link transmit state
   typedef struct packed {
      logic so; // Output bit
      logic oe; // Output driven
   } spe_tx_t;
   // Core side state
   typedef struct packed {
      logic cs_s1, cs_s2, cs_q; // Select sync and delay
      logic wp_s1, wp_s2; // Write protect sync
      logic [2:0] tg_s1, tg_s2, tg_q; // Event toggles
      logic armed; // Select seen high
      logic latch; // Write enable latch
      logic [1:0] prot; // Protect code
      spe_wkind_t kind; // Write being collected
      logic [8:0] base; // Start address
      logic [1:0] n; // Bytes collected
      logic [PAGE_BYTES-1:0] mask; // Bytes present
      logic [PAGE_BYTES-1:0][7:0] pbuf; // Page buffer
      logic partial; // Byte begun, not done
      spe_wkind_t run; // Write now timing
      logic go; // Start pulse
      logic standby; // Standby state
   } spe_rf_t;
   spe_lk_t lk_reg, lk_next;
   spe_ev_t ev_reg, ev_next;
   spe_tx_t tx_reg, tx_next;
   spe_rf_t rf_reg, rf_next;
   spe_wr_if wr_bus(); // Write timer link
   spe_stat_t st_core; // Status as driven by core flops
   logic [7:0] sh_in; // Shifter with new bit
   logic wr_ok; // Latch set, not busy
   logic [2:0] ev_hit; // Event arrivals
   logic [1:0] col; // Page column of next byte

   // ****************
   // Write timer
   // ****************
   spe_wr_eng #(
      .WR_CYCLES(WR_CYCLES)
   ) u_eng (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .wr(wr_bus)
   );
   assign wr_bus.start = rf_reg.go;

   // Status bits handed to the link, all from flops
   assign st_core = '{armed: rf_reg.armed, prot: rf_reg.prot, latch: rf_reg.latch, busy: wr_bus.busy};

   // ****************
   // Link receive
   // ****************
   // Decode of bits and bytes; array read is direct because
   // the array only changes while reads are refused
   always_comb begin
      lk_next = lk_reg;
      ev_next = ev_reg;
      lk_next.st_s1 = st_core;
      lk_next.st_s2 = lk_reg.st_s1;
      sh_in = {lk_reg.sh[6:0], si_i};
      wr_ok = lk_reg.st_s2.latch && !lk_reg.st_s2.busy;
      // Pause freezes the whole sequence
      if (pause_n_i) begin
         lk_next.sh = sh_in;
         lk_next.cnt = 3'(lk_reg.cnt + 3'h1);
         // First bit of a data byte marks it open
         if (lk_reg.cnt == 3'h0 && lk_reg.ph == PH_DATA) begin
            ev_next.beg_t = ~ev_reg.beg_t;
         end
         if (lk_reg.cnt == BYTE_LAST) begin
            case (lk_reg.ph)
               // Opcode complete
               PH_OPC: begin
                  lk_next.opc = sh_in;
                  lk_next.ph = PH_IGNORE;
                  if (!lk_reg.st_s2.armed) begin
                     lk_next.ph = PH_IGNORE;
                  end else if (sh_in == OP_SET_LATCH || sh_in == OP_CLR_LATCH) begin
                     // Rest of frame ignored; select must rise
                     ev_next.cmd = (sh_in == OP_SET_LATCH) ? CMD_SET : CMD_CLR;
                     ev_next.cmd_t = ~ev_reg.cmd_t;
                  end else if (sh_in == OP_RD_STAT) begin
                     lk_next.ph = PH_RD_STAT;
                     lk_next.out = stat_byte(lk_reg.st_s2);
                  end else if (sh_in == OP_WR_STAT && wr_ok) begin
                     lk_next.ph = PH_DATA;
                     ev_next.cmd = CMD_STAT;
                     ev_next.cmd_t = ~ev_reg.cmd_t;
                  end else if ((sh_in & OP_ARR_MASK) == OP_READ && !lk_reg.st_s2.busy) begin
                     lk_next.ph = PH_ADDR;
                     lk_next.rd = 1'b1;
                     lk_next.addr[8] = sh_in[OP_A8_POS];
                  end else if ((sh_in & OP_ARR_MASK) == OP_WRITE && wr_ok) begin
                     lk_next.ph = PH_ADDR;
                     lk_next.rd = 1'b0;
                     lk_next.addr[8] = sh_in[OP_A8_POS];
                  end
               end
               // Low address byte complete
               PH_ADDR: begin
                  lk_next.addr = {lk_reg.addr[8], sh_in};
                  if (lk_reg.rd) begin
                     lk_next.ph = PH_RD_ARR;
                     lk_next.out = mem[{lk_reg.addr[8], sh_in}];
                  end else begin
                     lk_next.ph = PH_DATA;
                     ev_next.cmd = CMD_ARR;
                     ev_next.cmd_addr = {lk_reg.addr[8], sh_in};
                     ev_next.cmd_t = ~ev_reg.cmd_t;
                  end
               end
               // Write data byte complete
               PH_DATA: begin
                  ev_next.byt = sh_in;
                  ev_next.byt_t = ~ev_reg.byt_t;
               end
               // Next array byte, wrapping at the top
               PH_RD_ARR: begin
                  lk_next.addr = 9'(lk_reg.addr + 9'h1);
                  lk_next.out = mem[9'(lk_reg.addr + 9'h1)];
               end
               // Status repeats with fresh content
               PH_RD_STAT: lk_next.out = stat_byte(lk_reg.st_s2);
               default: lk_next.ph = lk_reg.ph;
            endcase
         end
      end
   end

   // Receive flops; select high restarts the frame
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         lk_reg <= '0;
      end else begin
         lk_reg <= lk_next;
      end
   end

   // Event flops keep their toggles across frames
   always_ff @(negedge sck_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ev_reg <= '0;
      end else begin
         ev_reg <= ev_next;
      end
   end

   // ****************
   // Link transmit
   // ****************
   // Bit for the current position; held during pause
   always_comb begin
      tx_next = tx_reg;
      tx_next.oe = (lk_reg.ph == PH_RD_ARR || lk_reg.ph == PH_RD_STAT); // Stays driven so a pause resumes cleanly
      if (pause_n_i) begin
         tx_next.so = lk_reg.out[3'(BYTE_LAST - lk_reg.cnt)];
      end
   end

   // Rising-edge flops; select high releases the pin
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         tx_reg <= '0;
      end else begin
         tx_reg <= tx_next;
      end
   end

   // ****************
   // Core side
   // ****************
   // Events and select crossing; held words are stable for a
   // whole byte time after each toggle
   always_comb begin
      rf_next = rf_reg;
      rf_next.go = 1'b0;
      rf_next.cs_s1 = cs_n_i;
      rf_next.cs_s2 = rf_reg.cs_s1;
      rf_next.cs_q = rf_reg.cs_s2;
      rf_next.wp_s1 = write_protect_n_i;
      rf_next.wp_s2 = rf_reg.wp_s1;
      rf_next.tg_s1 = {ev_reg.byt_t, ev_reg.beg_t, ev_reg.cmd_t};
      rf_next.tg_s2 = rf_reg.tg_s1;
      rf_next.tg_q = rf_reg.tg_s2;
      ev_hit = rf_reg.tg_s2 ^ rf_reg.tg_q;
      // Power-up needs a deselect before any operation
      if (rf_reg.cs_s2) begin
         rf_next.armed = 1'b1;
      end
      // End of write cycle; a latch set arriving in the same cycle wins
      if (wr_bus.done) begin
         rf_next.latch = 1'b0;
         if (rf_reg.run == WK_STAT) begin
            rf_next.prot = rf_reg.pbuf[0][ST_PROT_POS +: 2];
         end
      end
      // Commands
      if (ev_hit[0]) begin
         case (ev_reg.cmd)
            CMD_SET: rf_next.latch = 1'b1;
            CMD_CLR: rf_next.latch = 1'b0;
            default: begin
               if (!wr_bus.busy) begin
                  rf_next.kind = (ev_reg.cmd == CMD_ARR) ? WK_ARR : WK_STAT;
                  rf_next.base = (ev_reg.cmd == CMD_ARR) ? ev_reg.cmd_addr : '0;
                  rf_next.n = '0;
                  rf_next.mask = '0;
                  rf_next.partial = 1'b0;
               end
            end
         endcase
      end
      // Data byte opened
      if (ev_hit[1]) begin
         rf_next.partial = 1'b1;
      end
      // Data byte closed; page column wraps
      col = (rf_next.kind == WK_ARR) ? 2'(rf_next.base[1:0] + rf_next.n) : 2'h0;
      if (ev_hit[2] && rf_next.kind != WK_NONE) begin
         rf_next.pbuf[col] = ev_reg.byt;
         rf_next.mask[col] = 1'b1;
         rf_next.n = 2'(rf_next.n + 2'h1);
         rf_next.partial = 1'b0;
      end
      // Protect low drops a write still being sent
      if (!rf_reg.wp_s2) begin
         rf_next.kind = WK_NONE;
      end
      // Select rise decides whether the write starts
      if (rf_reg.cs_s2 && !rf_reg.cs_q && rf_reg.armed) begin // Sync chain filling after reset is no rise
         if (rf_next.kind != WK_NONE && rf_next.mask != '0 && !rf_next.partial
             && rf_reg.latch && rf_reg.armed && !wr_bus.busy
             && !(rf_next.kind == WK_ARR && prot_hit(rf_reg.prot, rf_next.base))) begin
            rf_next.go = 1'b1;
            rf_next.run = rf_next.kind;
         end
         rf_next.kind = WK_NONE;
      end
      rf_next.standby = rf_reg.cs_s2 && !wr_bus.busy && !rf_reg.go;
   end

   // Core flops
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rf_reg <= '0;
         rf_reg.prot <= PROT_INIT;
      end else begin
         rf_reg <= rf_next;
      end
   end

   // Array update at the end of the write cycle
   always_ff @(posedge ref_clk_i) begin
      if (wr_bus.done && rf_reg.run == WK_ARR) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (rf_reg.mask[i]) begin
               mem[{rf_reg.base[8:2], 2'(i)}] <= rf_reg.pbuf[i];
            end
         end
      end
   end

   assign so_o = tx_reg.so;
   assign so_oe_o = tx_reg.oe;
   assign standby_o = rf_reg.standby;

   // ****************
   // Checks
   // ****************
   a_oe_desel: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) cs_n_i |-> !so_oe_o)
      else $error("Output driven while deselected");
   a_latch_clear: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      wr_bus.done && !(ev_hit[0] && ev_reg.cmd == CMD_SET) |=> !rf_reg.latch)
      else $error("Latch survived a write cycle");
   a_go_wp: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) rf_reg.go |-> $past(rf_reg.wp_s2))
      else $error("Write started while protected");
   a_go_latch: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) rf_reg.go |-> $past(rf_reg.latch))
      else $error("Write started without latch");
   a_go_rise: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rf_reg.go |-> $past(rf_reg.cs_s2 && !rf_reg.cs_q) ##1 wr_bus.busy)
      else $error("Write start not tied to select rise");
   a_go_armed: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) rf_reg.go |-> rf_reg.armed)
      else $error("Write before first deselect");
   a_go_prot: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rf_reg.go && rf_reg.run == WK_ARR |-> !prot_hit(rf_reg.prot, rf_reg.base))
      else $error("Write started into protected area");
   a_prot_src: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      $changed(rf_reg.prot) |-> $past(wr_bus.done && rf_reg.run == WK_STAT))
      else $error("Protect bits changed outside status write");
   c_arr_write: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) rf_reg.go && rf_reg.run == WK_ARR);
   c_stat_write: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) wr_bus.done && rf_reg.run == WK_STAT);
   c_read_out: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) $rose(so_oe_o));
   c_wp_abort: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) rf_reg.kind != WK_NONE && !rf_reg.wp_s2);
endmodule : spe_top
`default_nettype wire

// ===== verif/spe_host.sv
// Purpose: Host side of the serial link, acting as master
// Assumes: Link clock of 6 ns, standing low between frames
// Notes: Bytes seen on the data out line collect in rx_q per frame
`default_nettype none
module spe_host (
   output var logic sck_o,
   output var logic cs_n_o,
   output var logic si_o,
   output var logic pause_n_o,
   input wire logic so_i,
   input wire logic so_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // Link tasks
   // ****************
   logic [7:0] rx_q[$]; // Bytes read in this frame
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      pause_n_o = 1'b1; // Pause idles high
   end
   // Select; the odd delay keeps the link out of phase with the core clock
   task automatic sel;
      rx_q = {};
      #1.7 cs_n_o = 1'b0; // Falling select opens a frame
      #3;
   endtask : sel
   // Deselect; data line inverted so a stale bit is never mistaken
   task automatic desel;
      #3 cs_n_o = 1'b1; // Select low for the whole frame
      si_o = ~si_o;
      #30;
   endtask : desel
   // Shift n bits MSB first; pause around bit pb
   task automatic shift(input logic [7:0] tx, input int n, input int pb);
      logic [7:0] rx;
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         #3 sck_o = 1'b1;
         si_o = tx[i]; // MSB first
         if (i == pb) begin
            #1 pause_n_o = 1'b0; // Pause only while clock high
            #2 sck_o = 1'b0;
            si_o = ~tx[i]; // Bogus bit the device must ignore
            #3 sck_o = 1'b1;
            si_o = tx[i];
            #1 pause_n_o = 1'b1; // Release while clock high
            #2;
         end
         #3 sck_o = 1'b0;
         rx = {rx[6:0], so_oe_i ? so_i : ~so_i}; // Released line reads inverted
      end
      rx_q.push_back(rx);
   endtask : shift
   // One frame of whole bytes
   task automatic xfer(input logic [7:0] tx[$]);
      sel();
      foreach (tx[i]) shift(tx[i], 8, -1);
      desel();
   endtask : xfer
endmodule : spe_host
`default_nettype wire

// ===== verif/spi_eeprom_protect_read_test.sv
// Purpose: Self-checking bench of the serial memory slave
// Assumes: Host model drives the link; write cycles shortened to 64
// Notes: Array contents are only compared where written first
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
   $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module spi_eeprom_protect_read_test;
   timeunit 1ns;
   timeprecision 100ps;
   import spe_pkg::*;
   // ****************
   // Harness
   // ****************
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0; // Hang guard
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   wire logic sck, cs_n, si, pause_n, so, so_oe, standby;
   always #2.5 ref_clk = ~ref_clk;
   spe_top #(.WR_CYCLES(64)) spe_top_i (.ref_clk_i(ref_clk), .resetn_i(resetn), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .pause_n_i(pause_n), .write_protect_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .standby_o(standby));
   spe_host spe_host_i (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .pause_n_o(pause_n), .so_i(so), .so_oe_i(so_oe));
   // Ceiling far above the 1500 or so cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // ****************
   // Helpers
   // ****************
   task automatic rd_stat(output logic [7:0] s);
      spe_host_i.xfer('{OP_RD_STAT, 8'h00});
      s = spe_host_i.rx_q[1];
   endtask : rd_stat
   task automatic wr(input logic [8:0] a, input logic [7:0] d[$]);
      logic [7:0] tx[$];
      tx = '{{4'h0, a[8], 3'h2}, a[7:0]};
      foreach (d[i]) tx.push_back(d[i]);
      spe_host_i.xfer('{OP_SET_LATCH}); // Own frame first
      spe_host_i.xfer(tx);
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [7:0] e[$]);
      logic [7:0] tx[$];
      tx = '{{4'h0, a[8], 3'h3}, a[7:0]};
      foreach (e[i]) tx.push_back(8'h00);
      spe_host_i.xfer(tx);
      foreach (e[i]) `CHK(spe_host_i.rx_q[i + 2], e[i])
   endtask : rd
   task automatic wait_idle;
      repeat (8) @(posedge ref_clk);
      for (int n = 0; n < 400 && standby !== 1'b1; n++) @(posedge ref_clk);
      #1 `CHK(standby, 1'b1)
   endtask : wait_idle
   // ****************
   // Scenarios
   // ****************
   task automatic t_latch;
      logic [7:0] s;
      `CHK(so_oe, 1'b0)
      rd_stat(s);
      `CHK(s, 8'h00)
      spe_host_i.xfer('{OP_SET_LATCH});
      rd_stat(s);
      `CHK(s, 8'h02)
      spe_host_i.xfer('{OP_SET_LATCH, OP_WRITE, 8'h40, 8'h99});
      rd_stat(s);
      `CHK(s, 8'h02)
      spe_host_i.xfer('{OP_CLR_LATCH});
      rd_stat(s);
      `CHK(s, 8'h00)
   endtask : t_latch
   task automatic t_page;
      logic [7:0] s;
      wr(9'h000, '{8'h5A});
      rd_stat(s);
      `CHK(s, 8'hFF)
      `CHK(standby, 1'b0)
      wait_idle();
      rd_stat(s);
      `CHK(s, 8'h00)
      wr(9'h1FE, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4});
      wait_idle();
      rd(9'h1FC, '{8'hA2, 8'hA3, 8'hA4, 8'hA1, 8'h5A});
   endtask : t_page
   task automatic t_block;
      logic [7:0] s;
      spe_host_i.xfer('{OP_SET_LATCH});
      spe_host_i.xfer('{OP_WR_STAT, 8'h08}); // Zeros outside the protect field
      wait_idle();
      rd_stat(s);
      `CHK(s, 8'h08)
      wr(9'h1FC, '{8'h11});
      rd_stat(s);
      `CHK(s[0], 1'b0)
      wr(9'h0FC, '{8'h3C});
      wait_idle();
      rd(9'h0FC, '{8'h3C});
      rd(9'h1FC, '{8'hA2, 8'hA3});
      spe_host_i.xfer('{OP_SET_LATCH});
      spe_host_i.xfer('{OP_WR_STAT, 8'h00}); // Zeros outside the protect field
      wait_idle();
   endtask : t_block
   task automatic t_pause;
      spe_host_i.sel();
      spe_host_i.shift(8'h0B, 8, 4);
      spe_host_i.shift(8'hFC, 8, -1);
      spe_host_i.shift(8'h00, 8, 2);
      spe_host_i.desel();
      `CHK(spe_host_i.rx_q[2], 8'hA2)
      `CHK(so_oe, 1'b0)
   endtask : t_pause
   task automatic t_guard;
      logic [7:0] s;
      @(posedge ref_clk) wp_n <= 1'b0;
      wr(9'h000, '{8'hC3});
      rd_stat(s);
      `CHK(s[0], 1'b0)
      @(posedge ref_clk) wp_n <= 1'b1;
      spe_host_i.xfer('{OP_CLR_LATCH});
      spe_host_i.xfer('{OP_WRITE, 8'h00, 8'hC3});
      spe_host_i.xfer('{OP_SET_LATCH});
      spe_host_i.sel();
      spe_host_i.shift(OP_WRITE, 8, -1);
      spe_host_i.shift(8'h00, 8, -1);
      spe_host_i.shift(8'hC3, 8, -1);
      spe_host_i.shift(8'hC3, 7, -1); // Whole byte, then a cut one
      spe_host_i.desel();
      spe_host_i.xfer('{OP_SET_LATCH});
      spe_host_i.sel();
      spe_host_i.shift(OP_WRITE, 8, -1);
      spe_host_i.shift(8'h00, 8, -1);
      spe_host_i.shift(8'hC3, 8, -1);
      @(posedge ref_clk) wp_n <= 1'b0;
      repeat (4) @(posedge ref_clk) wp_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      spe_host_i.desel();
      wait_idle();
      rd(9'h000, '{8'h5A});
   endtask : t_guard
   initial begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (10) @(posedge ref_clk);
      t_latch();
      t_page();
      t_block();
      t_pause();
      t_guard();
      wrap_up();
   end
endmodule : spi_eeprom_protect_read_test
`default_nettype wire
